// ### hw/ipc_ctrl.sv
// Interrupt controller plus processor status/control register.
// Assumes core strobes and source pulses are on clk; USB line
// levels and bus activity come from pins and are synchronised.
`timescale 1ns/10ps
`include "ipc_map.svh"
module ipc_ctrl import ipc_pkg::*; #(
   parameter int SE0_CYC = `IPC_SE0_CYC,
   parameter int CALL_CYC = `IPC_CALL_CYC
) (
   input wire logic clk, // 10 MHz core clock
   input wire logic rst_n, // Power-on reset, async
   input wire logic wdog_rst, // Watchdog expiry pulse
   input wire logic [7:0] io_addr, // I/O port address
   input wire logic io_wr, // I/O write strobe
   input wire logic io_rd, // I/O read strobe
   input wire logic [7:0] io_wdata, // I/O write data
   output logic [7:0] io_rdata_q, // Read data, next cycle
   input wire logic instr_done, // Current instruction ends
   input wire logic op_halt, // Halt executed
   input wire logic op_di, // irq_disable_instruction
   input wire logic op_ei, // irq_enable_instruction
   input wire logic op_irq_return_instruction, // irq_return_instruction
   input wire ipc_stack_t core_state, // PC and flags now
   input wire ipc_stack_t pop_word, // Word popped by return
   input wire logic [12:1] src_evt, // Source pulses by vector
   input wire logic [5:0] glb_src_en, // Enables for 1,2,3,10,11,12
   input wire logic usb_dp, // Upstream D+ pin
   input wire logic usb_dm, // Upstream D- pin
   input wire logic usb_act, // Bus activity pin
   output logic cpu_run_q, // Core may execute
   output logic suspend_q, // Low-power suspend
   output logic gie_q, // Global interrupt enable
   output logic core_hold_q, // Core held for acknowledge
   output logic push_q, // Push stack word
   output ipc_stack_t push_word_q, // Saved PC and flags
   output logic call_q, // Jump to vector now
   output logic [15:0] vec_addr_q, // Vector address
   output logic restore_q, // Restore PC and flags
   output ipc_stack_t restore_word_q // Restored state
);
   // Lowest pending-and-enabled vector number, zero if none
   function automatic logic [3:0] pick_vec(input logic [12:1] req);
      logic [3:0] v;
      v = 4'h0;
      for (int i = 12; i >= 1; i--) begin
         if (req[i]) begin
            v = 4'(i);
         end
      end
      return v;
   endfunction : pick_vec

   ipc_status_t stat_q;
   logic [4:0] ep_en_q;
   logic [12:1] pend_q;
   logic [12:1] en_vec;
   logic [12:1] req;
   logic [3:0] win;
   logic [3:0] svc_q;
   ipc_state_t st_q;
   logic [3:0] cnt_q;
   logic [1:0] dp_s_q, dm_s_q, act_s_q;
   logic se0;
   logic [7:0] se0_cnt_q;
   logic se0_seen_q;
   logic wr_stat, wr_ep, clr_svc;
   logic [12:1] busrst_evt;

   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dp_s_q <= 2'b11;
         dm_s_q <= 2'b00;
         act_s_q <= 2'b00;
      end else begin
         dp_s_q <= {dp_s_q[0], usb_dp};
         dm_s_q <= {dm_s_q[0], usb_dm};
         act_s_q <= {act_s_q[0], usb_act};
      end
   end

   // Single-ended zero judged on the synchronised lines only
   assign se0 = !dp_s_q[1] && !dm_s_q[1];
   // Write decodes; reads decode inside the read port
   assign wr_stat = io_wr && io_addr == `IPC_ADDR_STATUS;
   assign wr_ep = io_wr && io_addr == `IPC_ADDR_EP_EN;

   // SE0 length counter; saturates so a long reset is still one event
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         se0_cnt_q <= 8'h00;
         se0_seen_q <= 1'b0;
      end else if (!se0) begin
         se0_cnt_q <= 8'h00;
         se0_seen_q <= 1'b0;
      end else begin
         if (se0_cnt_q != 8'hff) begin
            se0_cnt_q <= se0_cnt_q + 8'h01;
         end
         if (32'(se0_cnt_q) + 1 >= SE0_CYC) begin
            se0_seen_q <= 1'b1;
         end
      end
   end

   // Bus-reset event fires as SE0 ends, not as it starts
   assign busrst_evt = {11'h000, se0_seen_q && !se0};

   // Enable vector: endpoints from 0x21, vector 9 tied low, the rest from outside
   assign en_vec = {glb_src_en[5:3], 1'b0, ep_en_q, glb_src_en[2:0]};
   assign req = pend_q & en_vec;
   assign win = pick_vec(req);
   assign clr_svc = st_q == IPC_CLR;

   // Endpoint enable register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ep_en_q <= 5'h00;
      end else if (wdog_rst) begin
         ep_en_q <= 5'h00;
      end else if (wr_ep) begin
         ep_en_q <= io_wdata[4:0];
      end
   end

   // Per-source pending flops; vector 9 never pends
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= 12'h000;
      end else if (wdog_rst) begin
         pend_q <= 12'h000;
      end else begin
         for (int i = 1; i <= 12; i++) begin
            if (i != `IPC_VEC_RSVD && (src_evt[i] || busrst_evt[i])) begin
               pend_q[i] <= 1'b1;
            end else if (clr_svc && 32'(svc_q) == i) begin
               pend_q[i] <= 1'b0;
            end
         end
      end
   end

   // Global enable: changed only by DI, EI, return, acknowledge, halt and watchdog
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gie_q <= 1'b0;
      end else if (wdog_rst || op_halt) begin
         gie_q <= 1'b0;
      end else if (st_q == IPC_DIS) begin
         gie_q <= 1'b0;
      end else if (op_di) begin
         gie_q <= 1'b0;
      end else if (op_ei || op_irq_return_instruction) begin
         gie_q <= 1'b1;
      end
   end

   // Acknowledge sequencer: disable, clear flop, timed call
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= IPC_IDLE;
         svc_q <= 4'h0;
         cnt_q <= 4'h0;
      end else if (wdog_rst) begin
         st_q <= IPC_IDLE;
         svc_q <= 4'h0;
         cnt_q <= 4'h0;
      end else begin
         case (st_q)
            IPC_IDLE: begin
               if (instr_done && gie_q && win != 4'h0 && stat_q.run) begin
                  st_q <= IPC_DIS;
                  svc_q <= win;
               end
            end
            IPC_DIS: begin
               st_q <= IPC_CLR;
            end
            IPC_CLR: begin
               st_q <= IPC_CALL;
               cnt_q <= 4'h0;
            end
            IPC_CALL: begin
               // Ten cycles of call; the vector's jump costs the core five more
               // Ends at CALL_CYC-3 so hold spans ten cycles before the call
               if (32'(cnt_q) + 3 >= CALL_CYC) begin
                  st_q <= IPC_IDLE;
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            default: begin
               st_q <= IPC_IDLE;
            end
         endcase
      end
   end

   // Core-facing acknowledge outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_hold_q <= 1'b0;
         push_q <= 1'b0;
         push_word_q <= '0;
         call_q <= 1'b0;
         vec_addr_q <= `IPC_RESET_ADDR;
      end else if (wdog_rst) begin
         // Watchdog drops a running acknowledge at once, so no stray call
         core_hold_q <= 1'b0;
         push_q <= 1'b0;
         call_q <= 1'b0;
         vec_addr_q <= `IPC_RESET_ADDR;
      end else begin
         core_hold_q <= (st_q == IPC_IDLE && instr_done && gie_q && win != 4'h0 && stat_q.run)
                        || (st_q != IPC_IDLE && !(st_q == IPC_CALL && 32'(cnt_q) + 3 >= CALL_CYC));
         push_q <= st_q == IPC_CLR;
         if (st_q == IPC_CLR) begin
            push_word_q <= core_state;
         end
         call_q <= st_q == IPC_CALL && 32'(cnt_q) + 3 >= CALL_CYC;
         if (st_q == IPC_CLR) begin
            vec_addr_q <= {11'h000, svc_q, 1'b0};
         end
      end
   end

   // Return restores PC and flags
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         restore_q <= 1'b0;
         restore_word_q <= '0;
      end else begin
         restore_q <= op_irq_return_instruction;
         if (op_irq_return_instruction) begin
            restore_word_q <= pop_word;
         end
      end
   end

   // Status/control register; watchdog keeps POR and bus-reset flags
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_q <= ipc_status_t'(`IPC_STATUS_POR);
      end else if (wdog_rst) begin
         stat_q <= ipc_status_t'(`IPC_STATUS_WDR_SET | (stat_q & `IPC_STATUS_WDR_KEEP));
      end else if (op_halt) begin
         stat_q <= '0;
      end else begin
         if (wr_stat) begin
            stat_q.watchdog_reset_flag <= io_wdata[`IPC_BIT_WDR];
            stat_q.por <= io_wdata[`IPC_BIT_POR];
            stat_q.rsvd <= io_wdata[1];
            stat_q.run <= io_wdata[`IPC_BIT_RUN];
         end
         if (se0_seen_q) begin
            stat_q.busrst <= 1'b1;
         end else if (wr_stat) begin
            stat_q.busrst <= io_wdata[`IPC_BIT_BUSRST];
         end
         // Wake beats entry; entry refused while the bus is busy
         if (stat_q.susp && (req != 12'h000 || act_s_q[1])) begin
            stat_q.susp <= 1'b0;
         end else if (wr_stat && io_wdata[`IPC_BIT_SUSP] && !act_s_q[1]) begin
            stat_q.susp <= 1'b1;
         end else if (wr_stat && !io_wdata[`IPC_BIT_SUSP]) begin
            stat_q.susp <= 1'b0;
         end
         // Bits 7 and 2 are never stored; reads take live views
         stat_q.pend <= 1'b0;
         stat_q.ies <= 1'b0;
      end
   end

   // Read port; bits 7 and 2 are live views
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         io_rdata_q <= 8'h00;
      end else if (io_rd) begin
         if (io_addr == `IPC_ADDR_STATUS) begin
            io_rdata_q <= {pend_q != 12'h000, stat_q.watchdog_reset_flag, stat_q.busrst, stat_q.por,
                           stat_q.susp, gie_q, stat_q.rsvd, stat_q.run};
         end else if (io_addr == `IPC_ADDR_EP_EN) begin
            io_rdata_q <= {3'b000, ep_en_q};
         end else begin
            io_rdata_q <= 8'h00;
         end
      end
   end

   // Core run and suspend outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_run_q <= 1'b1;
         suspend_q <= 1'b0;
      end else if (wdog_rst) begin
         // Watchdog restarts a halted or suspended core
         cpu_run_q <= 1'b1;
         suspend_q <= 1'b0;
      end else begin
         cpu_run_q <= stat_q.run && !stat_q.susp && !op_halt;
         suspend_q <= stat_q.susp;
      end
   end
endmodule : ipc_ctrl

// ### hw/ipc_map.svh
// Constants for the interrupt and processor status/control block.
// Assumes a 10 MHz core clock; included by bare name.
`ifndef IPC_MAP_SVH
`define IPC_MAP_SVH
`define IPC_ADDR_EP_EN 8'h21
`define IPC_ADDR_STATUS 8'hff
`define IPC_STATUS_POR 8'h11
`define IPC_STATUS_WDR_SET 8'h41
`define IPC_STATUS_WDR_KEEP 8'h30
`define IPC_EP_EN_MASK 8'h1f
`define IPC_BIT_RUN 0
`define IPC_BIT_IES 2
`define IPC_BIT_SUSP 3
`define IPC_BIT_POR 4
`define IPC_BIT_BUSRST 5
`define IPC_BIT_WDR 6
`define IPC_BIT_PEND 7
`define IPC_RESET_ADDR 16'h0000
`define IPC_VEC_RSVD 9
`define IPC_NUM_VEC 12
`define IPC_CLK_KHZ 10000
`define IPC_SE0_MIN_NS 12000
`define IPC_SE0_CYC ((`IPC_SE0_MIN_NS * `IPC_CLK_KHZ + 999999) / 1000000)
`define IPC_CALL_CYC 10
`define IPC_JMP_CYC 5
`endif

// ### hw/ipc_pkg.sv
// Types shared by the interrupt and status/control block.
// Assumes ipc_map.svh supplies the numeric constants.
package ipc_pkg;
   typedef enum logic [1:0] {
      IPC_IDLE = 2'b00,
      IPC_DIS = 2'b01,
      IPC_CLR = 2'b11,
      IPC_CALL = 2'b10
   } ipc_state_t;

   typedef struct packed {
      logic pend;
      logic watchdog_reset_flag;
      logic busrst;
      logic por;
      logic susp;
      logic ies;
      logic rsvd;
      logic run;
   } ipc_status_t;

   typedef struct packed {
      logic carry_flag;
      logic zero_flag;
      logic [15:0] pc;
   } ipc_stack_t;
endpackage : ipc_pkg

// ### verification/ipc_core_model.sv
// Behavioural core: retires instructions, follows calls, keeps stack.
// Assumes the ipc_ctrl strobes share its clock.
`timescale 1ns/10ps
module ipc_core_model import ipc_pkg::*; (
   input wire logic clk, // Clock
   input wire logic rst_n, // Reset
   input wire logic run, // Core may run
   input wire logic hold, // Acknowledge owns core
   input wire logic push, // Push strobe
   input wire ipc_stack_t push_word, // Word pushed
   input wire logic call, // Call strobe
   input wire logic [15:0] vec, // Vector address
   output logic instr_done, // Instruction ends
   output ipc_stack_t core_state, // PC and flags
   output ipc_stack_t pop_word // Top of stack
);
   logic [1:0] cyc_q;
   // Three-cycle instructions; a held or stopped core retires nothing
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cyc_q <= 2'h0;
         core_state <= 18'h20000;
      end else if (call) begin
         core_state.pc <= vec;
      end else if (run && !hold) begin
         cyc_q <= (cyc_q == 2'h2) ? 2'h0 : cyc_q + 2'h1;
         if (cyc_q == 2'h2) begin
            core_state.pc <= core_state.pc + 16'h0001;
         end
      end
   end
   assign instr_done = run && !hold && cyc_q == 2'h2;
   // One-deep stack: handlers here never nest
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pop_word <= 18'h00000;
      end else if (push) begin
         pop_word <= push_word;
      end
   end
endmodule : ipc_core_model

// ### verification/ipc_ctrl_props.sv
// Port checks for ipc_ctrl: acknowledge timing, instruction effects.
// Bound to every ipc_ctrl instance; one clock domain.
`timescale 1ns/10ps
module ipc_ctrl_props import ipc_pkg::*; #(
   parameter int CALL_CYC = 10
) (
   input wire logic clk, // Clock
   input wire logic rst_n, // Reset
   input wire logic wdog_rst, // Watchdog
   input wire logic op_halt, // Halt
   input wire logic op_di, // Disable
   input wire logic op_ei, // Enable
   input wire logic op_irq_return_instruction, // Return
   input wire ipc_stack_t pop_word, // Popped
   input wire logic cpu_run_q, // Run
   input wire logic gie_q, // Global enable
   input wire logic core_hold_q, // Hold
   input wire logic push_q, // Push
   input wire logic call_q, // Call
   input wire logic [15:0] vec_addr_q, // Vector
   input wire logic restore_q, // Restore
   input wire ipc_stack_t restore_word_q // Restored
);
   localparam int PUSH_TO_CALL = CALL_CYC - 2;
   default clocking cb @(posedge clk);
   endclocking
   // A watchdog pulse aborts a running acknowledge, so it disables too
   default disable iff (!rst_n || wdog_rst);
   sequence s_drop_push;
      !gie_q ##1 push_q;
   endsequence
   a_ack_order: assert property ($rose(core_hold_q) |=> s_drop_push)
      else $error("acknowledge steps out of order");
   a_call_delay: assert property ($rose(core_hold_q) ##1 s_drop_push |-> ##PUSH_TO_CALL call_q)
      else $error("call not ten cycles after hold");
   a_hold_call: assert property ($fell(core_hold_q) && !$past(wdog_rst) |-> call_q)
      else $error("hold ended without call");
   a_vec_legal: assert property (push_q |-> vec_addr_q[0] == 1'b0 && vec_addr_q != 16'h0012 &&
      vec_addr_q >= 16'h0002 && vec_addr_q <= 16'h0018) else $error("bad vector address");
   a_halt_stop: assert property (op_halt |=> !cpu_run_q && !gie_q)
      else $error("halt did not stop core");
   a_di_clear: assert property (op_di && !op_ei && !op_irq_return_instruction |=> !gie_q)
      else $error("disable left enable set");
   a_ei_set: assert property (op_ei && !op_di && !op_halt && !core_hold_q |=> gie_q)
      else $error("enable not set");
   a_irq_return_instruction_back: assert property (op_irq_return_instruction && !op_halt && !core_hold_q |=>
      restore_q && gie_q && restore_word_q == $past(pop_word)) else $error("return not restored");
   a_wdog_clear: assert property (@(posedge clk) disable iff (!rst_n)
      wdog_rst |=> !gie_q && cpu_run_q && !core_hold_q) else $error("watchdog did not clear");
endmodule : ipc_ctrl_props
bind ipc_ctrl ipc_ctrl_props #(.CALL_CYC(CALL_CYC)) u_props (.clk(clk), .rst_n(rst_n), .wdog_rst(wdog_rst),
   .op_halt(op_halt), .op_di(op_di), .op_ei(op_ei), .op_irq_return_instruction(op_irq_return_instruction), .pop_word(pop_word), .cpu_run_q(cpu_run_q),
   .gie_q(gie_q), .core_hold_q(core_hold_q), .push_q(push_q), .call_q(call_q), .vec_addr_q(vec_addr_q),
   .restore_q(restore_q), .restore_word_q(restore_word_q));

// ### verification/tb.sv
// Self-checking bench for ipc_ctrl driven as firmware would drive it.
// Assumes ipc_core_model stands in for the core.
`timescale 1ns/10ps
module tb import ipc_pkg::*;;
   logic clk = 0, rst_n = 0, wdog_rst = 0, io_wr = 0, io_rd = 0, op_halt = 0;
   logic op_di = 0, op_ei = 0, op_irq_return_instruction = 0, usb_dp = 1, usb_dm = 0, usb_act = 0;
   logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, rd_q, io_rdata_q;
   logic [12:1] src_evt = 12'h000;
   logic [5:0] glb_src_en = 6'h01;
   logic cpu_run_q, suspend_q, gie_q, core_hold_q, push_q, call_q, restore_q, instr_done;
   logic [15:0] vec_addr_q;
   ipc_stack_t core_state, pop_word, push_word_q, restore_word_q;
   int err_count = 0, num_checks = 0, cyc = 0;
   ipc_ctrl #(.SE0_CYC(8)) u_ipc_ctrl (.clk(clk), .rst_n(rst_n), .wdog_rst(wdog_rst), .io_addr(io_addr),
      .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_q(io_rdata_q), .instr_done(instr_done),
      .op_halt(op_halt), .op_di(op_di), .op_ei(op_ei), .op_irq_return_instruction(op_irq_return_instruction), .core_state(core_state),
      .pop_word(pop_word), .src_evt(src_evt), .glb_src_en(glb_src_en), .usb_dp(usb_dp), .usb_dm(usb_dm),
      .usb_act(usb_act), .cpu_run_q(cpu_run_q), .suspend_q(suspend_q), .gie_q(gie_q), .core_hold_q(core_hold_q),
      .push_q(push_q), .push_word_q(push_word_q), .call_q(call_q), .vec_addr_q(vec_addr_q),
      .restore_q(restore_q), .restore_word_q(restore_word_q));
   ipc_core_model u_ipc_core_model (.clk(clk), .rst_n(rst_n), .run(cpu_run_q), .hold(core_hold_q),
      .push(push_q), .push_word(push_word_q), .call(call_q), .vec(vec_addr_q), .instr_done(instr_done),
      .core_state(core_state), .pop_word(pop_word));
   // 10 MHz clock and a hang limit well past the planned run
   initial forever #50 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc > 3000) begin
         err_count++;
         final_report();
      end
   end
   task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   // All drives land 1 ns after a rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // One idle edge after each strobe, so back-to-back calls never re-drive it at once
   task automatic pulse(ref logic s);
      s = 1;
      tick(1);
      s = 0;
      tick(1);
   endtask : pulse
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      io_addr = a;
      io_wdata = d;
      pulse(io_wr);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      io_addr = a;
      pulse(io_rd);
      rd_q = io_rdata_q;
   endtask : rd
   task automatic wait_call(input logic [15:0] v);
      for (int i = 0; i < 60 && call_q !== 1'b1; i++) tick(1);
      chk("call", 18'(call_q), 18'h1);
      chk("vector", 18'(vec_addr_q), 18'(v));
      chk("enable after ack", 18'(gie_q), 18'h0);
      chk("pushed state", push_word_q, core_state);
   endtask : wait_call
   task automatic t_reset;
      rd(8'hff);
      chk("status", 18'(rd_q), 18'h11);
      rd(8'h21);
      chk("ep enable", 18'(rd_q), 18'h0);
      rd(8'h22);
      chk("unmapped", 18'(rd_q), 18'h0);
   endtask : t_reset
   task automatic t_regs;
      wr(8'h21, 8'hff);
      rd(8'h21);
      chk("ep enable", 18'(rd_q), 18'h1f);
      wr(8'hff, 8'h85); // Bit 1 kept zero
      rd(8'hff);
      chk("status", 18'(rd_q), 18'h01);
      usb_act = 1;
      tick(3);
      wr(8'hff, 8'h09);
      rd(8'hff);
      chk("status", 18'(rd_q), 18'h01);
      usb_act = 0;
      tick(3);
      wr(8'hff, 8'h09);
      rd(8'hff);
      chk("status", 18'(rd_q), 18'h09);
      tick(1);
      chk("suspend", 18'({suspend_q, cpu_run_q}), 18'h2);
      usb_act = 1;
      tick(6);
      chk("woken", 18'({suspend_q, cpu_run_q}), 18'h1);
      usb_act = 0;
      wr(8'hff, 8'h01);
   endtask : t_regs
   task automatic t_irq;
      wr(8'h21, 8'h00);
      src_evt = 12'h090;
      tick(1);
      src_evt = 12'h000;
      rd(8'hff);
      chk("pending", 18'(rd_q[7]), 18'h1);
      pulse(op_ei);
      tick(12);
      chk("masked hold", 18'(core_hold_q), 18'h0);
      pulse(op_di);
      wr(8'h21, 8'h1f);
      rd(8'h21);
      chk("ep enable", 18'(rd_q), 18'h1f);
      rd(8'hff);
      chk("pending", 18'(rd_q[7]), 18'h1);
      pulse(op_ei);
      wait_call(16'h000a);
      rd(8'hff);
      chk("pending", 18'(rd_q[7]), 18'h1);
      op_irq_return_instruction = 1;
      tick(1);
      op_irq_return_instruction = 0;
      chk("restore", 18'({restore_q, gie_q}), 18'h3);
      chk("restored", restore_word_q, pop_word);
      wait_call(16'h0010);
      rd(8'hff);
      chk("pending", 18'(rd_q[7]), 18'h0);
   endtask : t_irq
   task automatic t_se0;
      usb_dp = 0;
      tick(14);
      rd(8'hff);
      chk("bus reset", 18'(rd_q[7:5]), 18'h1);
      usb_dp = 1;
      tick(4);
      rd(8'hff);
      chk("pending", 18'(rd_q[7]), 18'h1);
      pulse(op_ei);
      wait_call(16'h0002);
   endtask : t_se0
   task automatic t_wdog;
      wr(8'hff, 8'h31);
      pulse(wdog_rst);
      rd(8'hff);
      chk("status", 18'(rd_q), 18'h71);
      rd(8'h21);
      chk("ep enable", 18'(rd_q), 18'h0);
   endtask : t_wdog
   task automatic t_halt;
      pulse(op_halt);
      chk("run", 18'(cpu_run_q), 18'h0);
      rd(8'hff);
      chk("status", 18'(rd_q), 18'h0);
      pulse(wdog_rst);
      chk("run", 18'(cpu_run_q), 18'h1);
      rd(8'hff);
      chk("status", 18'(rd_q), 18'h41);
   endtask : t_halt
   initial begin
      tick(10);
      rst_n = 1;
      t_reset();
      t_regs();
      t_irq();
      t_se0();
      t_wdog();
      t_halt();
      final_report();
   end
endmodule : tb
